// file: shared/rss_cfg.svh
// Constants for the reset start-up sequencer: register offsets, field positions,
// reset values and timing figures.
// Assumes it is included by bare name from the package and the sequencer module.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define RSS_CTRL_OFS 8'h00
`define RSS_STAT_OFS 8'h04
`define RSS_CNT_OFS 8'h08

// Field positions inside the registers.
`define RSS_CTRL_HOLD_BIT 0
`define RSS_STAT_STATE_LSB 0
`define RSS_STAT_CAUSE_LSB 4
`define RSS_CNT_SEQ_LSB 0
`define RSS_CNT_BRN_LSB 16

// Reset values.
`define RSS_CTRL_RST 1'b0
`define RSS_CAUSE_RST 4'h0

// AXI4-Lite response codes.
`define RSS_RESP_OKAY 2'b00
`define RSS_RESP_SLVERR 2'b10

// Timing figures in their own units.
`define RSS_CLK_NS 8
`define RSS_DELAY_MS 72
`define RSS_RC_OSC_HZ 16000
`define RSS_START_CYCLES 1024
`define RSS_BMIN_NS 100000

// Derived counts: delay in RC oscillator periods, filter in aclk cycles (rounded up).
`define RSS_DELAY_RC_CYC ((`RSS_DELAY_MS * `RSS_RC_OSC_HZ) / 1000)
`define RSS_BMIN_CYC ((`RSS_BMIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

`endif

// file: shared/rss_pkg.sv
// Types shared by the reset start-up sequencer modules.
// Assumes the constant header is on the include path.
`include "rss_cfg.svh"

package rss_pkg;

    // Oscillator configuration from the fuses; three crystal modes and RC.
    typedef enum logic [1:0] {
        RSS_OSC_LOW_POWER,
        RSS_OSC_STANDARD,
        RSS_OSC_HIGH_SPEED,
        RSS_OSC_RC
    } rss_osc_mode_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        RSS_HOLD,
        RSS_DELAY,
        RSS_START,
        RSS_RUN,
        RSS_WAKE
    } rss_state_t;

    // Entire state of the sequencer, registered as one word.
    typedef struct packed {
        rss_state_t st;       // Sequencer state.
        logic [15:0] cnt;     // Power-up delay or start-up counter.
        logic [15:0] brn_cnt; // Brown-out duration filter.
        logic por_done;       // Supply has risen once since power-up.
        logic pend_delay;     // Power-up delay owed by the current reset.
        logic pend_start;     // Start-up count owed by the current reset.
        logic bor_act;        // Filtered brown-out reset active.
        logic rc_q;           // Previous RC oscillator level.
        logic osc_q;          // Previous oscillator input level.
        logic chip_rst_n;     // Internal chip reset, active low.
        logic core_hold;      // Core clock held during wake-up count.
        logic [3:0] cause;    // Sticky reset causes.
        logic ctrl_hold;      // Software reset hold.
        logic aw_got;         // Write address taken.
        logic w_got;          // Write data taken.
        logic [7:0] awaddr;   // Latched write address.
        logic [31:0] wdata;   // Latched write data.
        logic [3:0] wstrb;    // Latched write strobes.
        logic bvalid;         // Write response pending.
        logic [1:0] bresp;    // Write response code.
        logic rvalid;         // Read data pending.
        logic [1:0] rresp;    // Read response code.
        logic [31:0] rdata;   // Read data.
    } rss_regs_t;

endpackage

// file: rtl/rss_sync.sv
// Two-flop synchroniser for a vector of slow asynchronous levels.
// Assumes each bit is independent; no bus coherence is promised.
`timescale 1ns/1ps

module rss_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage, read only by the second stage.
    logic [W-1:0] meta_r;

    // Both stages clear on reset and then follow the pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: rtl/rss_seq.sv
// Reset start-up sequencer: power-on, brown-out and pin reset, power-up delay
// and oscillator start-up count, with an AXI4-Lite register slave.
// Assumes supply monitor, fuse and oscillator pins are asynchronous levels and
// that the oscillator input is well below half the aclk rate.
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_seq #(
    parameter int DELAY_CYC = `RSS_DELAY_RC_CYC,
    parameter int START_CYC = `RSS_START_CYCLES,
    parameter int BMIN_CYC = `RSS_BMIN_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_clear_n,
    input wire logic supply_por_ok,
    input wire logic brownout_detect,
    input wire logic rc_osc_in,
    input wire logic osc_input,
    input wire logic powerup_delay_disable_fuse,
    input wire logic brownout_enable_fuse,
    input wire rss_pkg::rss_osc_mode_t osc_mode,
    input wire logic sleep_wake,
    input wire logic wdt_reset,
    output logic chip_reset_n,
    output logic core_clock_hold,
    output rss_pkg::rss_state_t seq_state,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rss_pkg::*;

    // True in the three crystal oscillator modes.
    function automatic logic is_xtal(input rss_osc_mode_t m);
        is_xtal = (m != RSS_OSC_RC);
    endfunction

    // True for a mapped register offset.
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `RSS_CTRL_OFS) || (a == `RSS_STAT_OFS) || (a == `RSS_CNT_OFS);
    endfunction

    rss_regs_t s; // Registered state.
    rss_regs_t n; // Next state.
    logic [8:0] pins_s; // Synchronised pins.
    logic mclear_s; // Master clear, synchronised.
    logic por_ok_s; // Supply adequate, synchronised.
    logic below_s; // Supply below brown-out threshold, synchronised.
    logic rc_s; // RC oscillator level, synchronised.
    logic osc_s; // Oscillator input level, synchronised.
    logic delay_dis_s; // Power-up delay disable fuse, synchronised.
    logic brn_en_s; // Brown-out enable fuse, synchronised.
    rss_osc_mode_t mode_s; // Oscillator mode, synchronised.
    logic below; // Qualified low supply.
    logic src_any; // Some reset source is asserted.
    logic rc_edge; // Rising RC oscillator edge.
    logic osc_edge; // Rising oscillator input edge.
    logic xtal; // Crystal mode selected.
    logic wr_fire; // Write address and data both present.
    logic rd_fire; // Read address accepted.

    // All pins but sleep_wake and wdt_reset cross two flip-flops before any logic reads them.
    rss_sync #(.W(9)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({master_clear_n, supply_por_ok, brownout_detect, rc_osc_in, osc_input,
            powerup_delay_disable_fuse, brownout_enable_fuse, osc_mode}),
        .q(pins_s)
    );

    // Unpack the synchronised pins.
    assign mclear_s = pins_s[8];
    assign por_ok_s = pins_s[7];
    assign below_s = pins_s[6];
    assign rc_s = pins_s[5];
    assign osc_s = pins_s[4];
    assign delay_dis_s = pins_s[3];
    assign brn_en_s = pins_s[2];
    assign mode_s = rss_osc_mode_t'(pins_s[1:0]);

    // Handshake outputs follow the registered transaction state.
    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready = !s.w_got && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign chip_reset_n = s.chip_rst_n;
    assign core_clock_hold = s.core_hold;
    assign seq_state = s.st;

    // Source qualification and edge detection.
    assign below = brn_en_s && below_s;
    assign rc_edge = rc_s && !s.rc_q;
    assign osc_edge = osc_s && !s.osc_q;
    assign xtal = is_xtal(mode_s);
    assign src_any = !s.por_done || s.bor_act || !mclear_s || s.ctrl_hold || wdt_reset;
    assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
    assign rd_fire = s_axi_arvalid && !s.rvalid;

    // Next-state logic for the sequencer and the register slave.
    always_comb begin
        n = s;
        n.rc_q = rc_s;
        n.osc_q = osc_s;
        // Once the supply has been good, a later fall is left to brown-out.
        if (por_ok_s) begin
            n.por_done = 1'b1;
        end
        // Brown-out filter: a dip must outlast the minimum duration.
        if (below) begin
            if (s.brn_cnt != 16'(BMIN_CYC - 1)) begin
                n.brn_cnt = s.brn_cnt + 16'h0001;
            end else begin
                n.bor_act = 1'b1;
            end
        end else begin
            n.brn_cnt = 16'h0000;
            n.bor_act = 1'b0;
        end
        // Sequencer.
        case (s.st)
            RSS_HOLD: begin
                n.cnt = 16'h0000;
                if (src_any || below) begin
                    n.st = RSS_HOLD;
                end else if (s.pend_delay && !delay_dis_s) begin
                    n.st = RSS_DELAY;
                end else if (s.pend_start && xtal) begin
                    n.st = RSS_START;
                end else begin
                    n.st = RSS_RUN;
                    n.pend_delay = 1'b0;
                    n.pend_start = 1'b0;
                end
            end
            RSS_DELAY: begin
                if (src_any || below) begin
                    n.st = RSS_HOLD;
                    n.cnt = 16'h0000;
                end else if (rc_edge) begin
                    if (s.cnt == 16'(DELAY_CYC - 1)) begin
                        n.cnt = 16'h0000;
                        if (s.pend_start && xtal) begin
                            n.st = RSS_START;
                        end else begin
                            n.st = RSS_RUN;
                            n.pend_delay = 1'b0;
                            n.pend_start = 1'b0;
                        end
                    end else begin
                        n.cnt = s.cnt + 16'h0001;
                    end
                end
            end
            RSS_START, RSS_WAKE: begin
                if (src_any || below) begin
                    n.st = RSS_HOLD;
                    n.cnt = 16'h0000;
                end else if (osc_edge) begin
                    if (s.cnt == 16'(START_CYC - 1)) begin
                        n.cnt = 16'h0000;
                        n.st = RSS_RUN;
                        n.pend_delay = 1'b0;
                        n.pend_start = 1'b0;
                    end else begin
                        n.cnt = s.cnt + 16'h0001;
                    end
                end
            end
            RSS_RUN: begin
                if (src_any) begin
                    n.st = RSS_HOLD;
                end else if (sleep_wake && xtal) begin
                    n.st = RSS_WAKE;
                    n.cnt = 16'h0000;
                end
            end
            default: begin
                n.st = RSS_HOLD;
            end
        endcase
        // Power-on owes both delays, brown-out only the power-up delay; set after any clear.
        if (!s.por_done || s.bor_act) begin
            n.pend_delay = 1'b1;
        end
        if (!s.por_done) begin
            n.pend_start = 1'b1;
        end
        // Register write: taken when both address and data are held.
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = reg_hit(s.awaddr) ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
            if (s.awaddr == `RSS_CTRL_OFS && s.wstrb[0]) begin
                n.ctrl_hold = s.wdata[`RSS_CTRL_HOLD_BIT];
            end
            if (s.awaddr == `RSS_STAT_OFS && s.wstrb[0]) begin
                n.cause = s.cause & ~s.wdata[`RSS_STAT_CAUSE_LSB +: 4];
            end
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Sticky causes: a new event wins over a clear in the same cycle.
        // The pin cause waits for power-on, as the synchroniser reads low until it is primed.
        n.cause = n.cause | {wdt_reset || s.ctrl_hold, s.por_done && !mclear_s,
            s.bor_act, !s.por_done};
        // Register read.
        if (rd_fire) begin
            n.rvalid = 1'b1;
            n.rresp = reg_hit(s_axi_araddr) ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                `RSS_CTRL_OFS: begin
                    n.rdata[`RSS_CTRL_HOLD_BIT] = s.ctrl_hold;
                end
                `RSS_STAT_OFS: begin
                    n.rdata[`RSS_STAT_STATE_LSB +: 3] = s.st;
                    n.rdata[`RSS_STAT_CAUSE_LSB +: 4] = s.cause;
                end
                `RSS_CNT_OFS: begin
                    n.rdata[`RSS_CNT_SEQ_LSB +: 16] = s.cnt;
                    n.rdata[`RSS_CNT_BRN_LSB +: 16] = s.brn_cnt;
                end
                default: begin
                    n.rdata = 32'h0000_0000;
                end
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        // Chip leaves reset only in the running and wake states.
        n.chip_rst_n = (n.st == RSS_RUN) || (n.st == RSS_WAKE);
        n.core_hold = (n.st == RSS_WAKE);
    end

    // State register; synchronous reset brings the chip into reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.cause <= `RSS_CAUSE_RST;
            s.ctrl_hold <= `RSS_CTRL_RST;
        end else begin
            s <= n;
        end
    end

    // Checks on the sequencer.
    localparam int DELAY_LAST = DELAY_CYC - 1;
    localparam int START_LAST = START_CYC - 1;
    localparam int BMIN_LAST = BMIN_CYC - 1;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    por_hold_a: assert property (!s.por_done |=> !chip_reset_n)
        else $error("chip released before supply was adequate");
    por_once_a: assert property ($past(s.por_done) |-> s.por_done)
        else $error("power-on detect rearmed after supply fall");
    delay_cause_a: assert property (s.st == RSS_DELAY |-> s.pend_delay)
        else $error("power-up delay ran for a non power cause");
    delay_rc_a: assert property (s.st == RSS_DELAY && n.st == RSS_DELAY && !rc_edge
        |=> $stable(s.cnt))
        else $error("power-up delay advanced without an RC edge");
    delay_len_a: assert property (s.st == RSS_DELAY ##1 s.st inside {RSS_START, RSS_RUN}
        |-> $past(s.cnt) == 16'(DELAY_LAST))
        else $error("power-up delay ended at wrong count");
    delay_skip_a: assert property (s.st == RSS_HOLD && delay_dis_s |=> s.st != RSS_DELAY)
        else $error("power-up delay ran with disable fuse set");
    start_len_a: assert property (s.st == RSS_START ##1 s.st == RSS_RUN
        |-> $past(s.cnt) == 16'(START_LAST) && $past(osc_edge))
        else $error("start-up count ended early");
    start_mode_a: assert property (s.st inside {RSS_START, RSS_WAKE} |-> $past(xtal))
        else $error("start-up count in RC mode");
    brn_off_a: assert property (!brn_en_s |=> !s.bor_act)
        else $error("brown-out active while disabled");
    brn_filter_a: assert property ($rose(s.bor_act) |-> $past(s.brn_cnt) == 16'(BMIN_LAST))
        else $error("brown-out fired before minimum duration");
    brn_hold_a: assert property (below && s.st == RSS_HOLD |=> s.st == RSS_HOLD)
        else $error("left reset with supply below threshold");
    delay_restart_a: assert property (s.st == RSS_DELAY && below
        |=> s.st == RSS_HOLD && s.cnt == 16'h0000)
        else $error("power-up delay not reinitialised on dip");
    pin_hold_a: assert property (!mclear_s |=> !chip_reset_n)
        else $error("chip out of reset with master clear low");
    release_a: assert property ($rose(chip_reset_n) |-> $past(!src_any))
        else $error("released while a reset source was asserted");

    delay_done_c: cover property (s.st == RSS_DELAY ##1 s.st == RSS_START);
    start_done_c: cover property (s.st == RSS_START ##1 s.st == RSS_RUN);
    brn_reset_c: cover property ($rose(s.bor_act));
    wake_c: cover property (s.st == RSS_WAKE ##1 s.st == RSS_RUN);
endmodule

// file: dv/rss_far_model.sv
// Far-side model of the sequencer: supply monitors, reset pin and the two oscillators.
// Assumes the bench steers it with plain control levels; all outputs are async pins.
`timescale 1ns/1ps

module rss_far_model (
    input wire logic por_up,
    input wire logic dip,
    input wire logic pin_low,
    input wire logic rc_run,
    input wire logic osc_run,
    output logic supply_por_ok,
    output logic brownout_detect,
    output logic master_clear_n,
    output logic rc_osc_in,
    output logic osc_input
);
    // The power-on detector reports an adequate supply once it has risen.
    assign supply_por_ok = por_up;
    // The brown-out comparator reports a supply below its threshold.
    assign brownout_detect = dip;
    // The pin is pulled up and only driven low while a reset is commanded.
    assign master_clear_n = ~pin_low;

    // RC oscillator, 80 ns period; it stands still while stopped.
    initial begin
        rc_osc_in = 1'b0;
        forever begin
            #40;
            if (rc_run) begin
                rc_osc_in = ~rc_osc_in;
            end
        end
    end

    // Crystal input, 56 ns period; it stays flat until the crystal starts.
    initial begin
        osc_input = 1'b0;
        forever begin
            #28;
            if (osc_run) begin
                osc_input = ~osc_input;
            end
        end
    end
endmodule

// file: dv/reset_startup_sequencer_tb_top.sv
// Self-checking bench for the reset start-up sequencer with AXI4-Lite register access.
// Assumes the far-side model drives the analog and pin inputs; counts are shortened.
`timescale 1ns/1ps

module reset_startup_sequencer_tb_top;
    import rss_pkg::*;
    localparam int NP = 4; // Short delay, start-up and filter counts.
    logic aclk, aresetn, master_clear_n, supply_por_ok, brownout_detect, rc_osc_in, osc_input;
    logic powerup_delay_disable_fuse, brownout_enable_fuse, sleep_wake, wdt_reset;
    logic chip_reset_n, core_clock_hold;
    rss_osc_mode_t osc_mode;
    rss_state_t seq_state;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic por_up, dip, pin_low, rc_run, osc_run, seen_clr;
    logic [7:0] seen; // States visited since the last clear.
    int fails, checked, n;

    rss_seq #(.DELAY_CYC(NP), .START_CYC(NP), .BMIN_CYC(NP)) i_dut (.aclk, .aresetn,
        .master_clear_n, .supply_por_ok, .brownout_detect, .rc_osc_in, .osc_input,
        .powerup_delay_disable_fuse, .brownout_enable_fuse, .osc_mode, .sleep_wake,
        .wdt_reset, .chip_reset_n, .core_clock_hold, .seq_state, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    rss_far_model i_far (.por_up, .dip, .pin_low, .rc_run, .osc_run, .supply_por_ok,
        .brownout_detect, .master_clear_n, .rc_osc_in, .osc_input);

    // The 125 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Records every state shown, so skipped phases can be detected.
    always @(posedge aclk) begin
        if (seen_clr) begin
            seen <= '0;
        end else begin
            seen[seq_state] <= 1'b1;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waits a bounded number of cycles for a state, then compares it.
    task automatic wait_st(input rss_state_t st, input int lim);
        int k;
        k = 0;
        while (seq_state !== st && k < lim) begin
            @(posedge aclk);
            #1;
            k++;
        end
        chk("seq_state", 32'(st), 32'(seq_state));
    endtask

    // Counts the cycles until the sequencer runs, then compares the state.
    task automatic to_run(output int c);
        c = 0;
        while (seq_state !== RSS_RUN && c < 400) begin
            @(posedge aclk);
            #1;
            c++;
        end
        chk("seq_state", 32'(RSS_RUN), 32'(seq_state));
    endtask

    // Lets a number of cycles pass and samples after the edge has settled.
    task automatic idle(input int c);
        repeat (c) @(posedge aclk);
        #1;
    endtask

    // Clears the record of visited states.
    task automatic clr_seen;
        @(posedge aclk);
        seen_clr <= 1'b1;
        @(posedge aclk);
        seen_clr <= 1'b0;
    endtask

    // One AXI4-Lite write: address and data offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // One AXI4-Lite read; data and response are taken at the edge that shows rvalid.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Cuts a hung run short.
    initial begin
        #100000;
        fails++;
        end_sim();
    end

    // Main sequence.
    initial begin
        fails = 0;
        checked = 0;
        {aresetn, por_up, dip, pin_low, rc_run, osc_run, seen_clr} = '0;
        {powerup_delay_disable_fuse, brownout_enable_fuse, sleep_wake, wdt_reset} = '0;
        osc_mode = RSS_OSC_STANDARD;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        rc_run = 1'b1;
        idle(20);
        aresetn <= 1'b1;
        s_axi_wstrb <= 4'hf;
        idle(20);
        chk("chip_reset_n", 0, chip_reset_n);
        por_up <= 1'b1;
        osc_run <= 1'b1;
        wait_st(RSS_DELAY, 20);
        wait_st(RSS_START, 100);
        to_run(n);
        chk("start_len", 1, n >= 20);
        chk("chip_reset_n", 1, chip_reset_n);
        axi_rd(8'h04, rd, rsp);
        chk("stat", 32'h13, rd);
        axi_wr(8'h04, 32'hf0, rsp);
        axi_rd(8'h04, rd, rsp);
        chk("stat", 32'h03, rd);
        axi_wr(8'h00, 32'h1, rsp);
        chk("bresp", 2'b00, rsp);
        wait_st(RSS_HOLD, 10);
        clr_seen();
        axi_wr(8'h00, 32'h0, rsp);
        to_run(n);
        chk("seen_delay", 0, seen[RSS_DELAY]);
        axi_rd(8'h00, rd, rsp);
        chk("ctrl", 0, rd);
        axi_rd(8'h0c, rd, rsp);
        chk("rresp", 2'b10, rsp);
        chk("rdata", 0, rd);
        axi_wr(8'h0c, 32'h1, rsp);
        chk("bresp", 2'b10, rsp);
        @(posedge aclk);
        por_up <= 1'b0;
        idle(30);
        chk("chip_reset_n", 1, chip_reset_n);
        por_up <= 1'b1;
        dip <= 1'b1;
        idle(30);
        chk("chip_reset_n", 1, chip_reset_n);
        dip <= 1'b0;
        brownout_enable_fuse <= 1'b1;
        idle(5);
        dip <= 1'b1;
        idle(2);
        dip <= 1'b0;
        idle(20);
        chk("chip_reset_n", 1, chip_reset_n);
        dip <= 1'b1;
        wait_st(RSS_HOLD, 20);
        idle(20);
        chk("chip_reset_n", 0, chip_reset_n);
        rc_run <= 1'b0;
        dip <= 1'b0;
        clr_seen();
        wait_st(RSS_DELAY, 20);
        idle(60);
        wait_st(RSS_DELAY, 0);
        rc_run <= 1'b1;
        idle(15);
        dip <= 1'b1;
        wait_st(RSS_HOLD, 10);
        dip <= 1'b0;
        wait_st(RSS_DELAY, 20);
        to_run(n);
        chk("delay_len", 1, n >= 30);
        chk("seen_start", 0, seen[RSS_START]);
        powerup_delay_disable_fuse <= 1'b1;
        dip <= 1'b1;
        wait_st(RSS_HOLD, 20);
        dip <= 1'b0;
        clr_seen();
        to_run(n);
        chk("seen_delay", 0, seen[RSS_DELAY]);
        powerup_delay_disable_fuse <= 1'b0;
        pin_low <= 1'b1;
        wait_st(RSS_HOLD, 10);
        idle(30);
        chk("chip_reset_n", 0, chip_reset_n);
        pin_low <= 1'b0;
        clr_seen();
        to_run(n);
        chk("seen_delay", 0, seen[RSS_DELAY]);
        wdt_reset <= 1'b1;
        wait_st(RSS_HOLD, 10);
        wdt_reset <= 1'b0;
        to_run(n);
        osc_mode <= RSS_OSC_RC;
        idle(5);
        sleep_wake <= 1'b1;
        @(posedge aclk);
        sleep_wake <= 1'b0;
        idle(10);
        chk("core_clock_hold", 0, core_clock_hold);
        osc_mode <= RSS_OSC_HIGH_SPEED;
        idle(5);
        sleep_wake <= 1'b1;
        @(posedge aclk);
        sleep_wake <= 1'b0;
        wait_st(RSS_WAKE, 10);
        chk("core_clock_hold", 1, core_clock_hold);
        chk("chip_reset_n", 1, chip_reset_n);
        to_run(n);
        end_sim();
    end
endmodule
